// ### logic/usfc_params.svh
/*
 Constants of the serial transceiver core: register offsets, field
 positions, reset values and counts.
 Assumes the includer decodes the low eight address bits only.
*/
`ifndef USFC_PARAMS_SVH
`define USFC_PARAMS_SVH
// ==========================================
// register byte offsets
`define USFC_OFS_DATA   8'h00
`define USFC_OFS_CSRA   8'h04
`define USFC_OFS_CSRB   8'h08
`define USFC_OFS_CSRC   8'h0C
`define USFC_OFS_BDLO   8'h10
`define USFC_OFS_BDHI   8'h14
// ==========================================
// control_status_a bits
`define USFC_A_U2X      0
`define USFC_A_RXC      1
`define USFC_A_UDRE     2
`define USFC_A_TXC      3
`define USFC_A_FE       4
`define USFC_A_DOR      5
`define USFC_A_PE       6
// ==========================================
// control_status_b bits
`define USFC_B_RXEN     0
`define USFC_B_TXEN     1
`define USFC_B_TX9      2
`define USFC_B_XCKDIR   3
`define USFC_B_TXCIE    4
`define USFC_B_UDRIE    5
`define USFC_B_RXCIE    6
// ==========================================
// control_status_c fields (lsb positions)
`define USFC_C_CSZ      0
`define USFC_C_PM       3
`define USFC_C_SBS      5
`define USFC_C_UMSEL    6
`define USFC_C_UCPOL    7
`define USFC_RST_C      8'h06
// ==========================================
// frame and timing counts
`define USFC_CSZ_NINE   3'h7
`define USFC_BITS_NINE  4'h9
`define USFC_BITS_EIGHT 4'h8
`define USFC_MIN_BITS   4'h5
`define USFC_FRAME_BASE 4'h2
`define USFC_OS_NORM    4'hF
`define USFC_OS_DBL     4'h7
`define USFC_MID_NORM   4'h7
`define USFC_MID_DBL    4'h3
`define USFC_CNT_ZERO   12'h000
`define USFC_FIFO_DEPTH 2'h2
`define USFC_RESP_OKAY  2'h0
`define USFC_RESP_SLVERR 2'h2
`endif

// ### logic/usfc_pkg.sv
/*
 Types of the serial transceiver core.
 Assumes nothing of its surroundings.
*/
package usfc_pkg;
	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} usfc_rx_state_t;
endpackage

// ### logic/usfc_tick_if.sv
/*
 Bit timing enables from the clock generator to its users.
 Assumes one clock; every signal is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none
interface usfc_tick_if;
	logic txBitEn;
	logic rxTick;
	logic syncChange;
	logic syncSample;
	modport gen  (output txBitEn, rxTick, syncChange, syncSample);
	modport sink (input  txBitEn, rxTick, syncChange, syncSample);
endinterface
`default_nettype wire

// ### logic/usfc_baud_gen.sv
/*
 Baud down-counter, transmit divider and transfer clock logic.
 Assumes the pin input xckIn is asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "usfc_params.svh"
module usfc_baud_gen (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [11:0] baudDiv,
	input  wire logic        reload,
	input  wire logic        syncMode,
	input  wire logic        slaveMode,
	input  wire logic        dblSpeed,
	input  wire logic        polarity,
	input  wire logic        runClk,
	input  wire logic        xckIn,
	output logic             xckOut,
	usfc_tick_if.gen         tk
);
	logic [11:0] cnt_r;
	logic [3:0]  div_r;
	logic        xs1_r;
	logic        xs2_r;
	logic        xsPrev_r;

	wire       baudTick = (cnt_r == `USFC_CNT_ZERO);
	wire [3:0] divMax   = dblSpeed ? `USFC_OS_DBL : `USFC_OS_NORM;
	wire       master   = syncMode && !slaveMode;
	wire       toggle   = baudTick && master &&
	                      (runClk || (xckOut != polarity));
	wire       rise     = xs2_r && !xsPrev_r;
	wire       fall     = !xs2_r && xsPrev_r;

	assign tk.rxTick     = baudTick && !syncMode;
	assign tk.txBitEn    = tk.rxTick && (div_r == divMax);
	assign tk.syncChange = master ? (toggle && (xckOut == polarity)) :
	                       (syncMode && (polarity ? fall : rise));
	assign tk.syncSample = master ? (toggle && (xckOut != polarity)) :
	                       (syncMode && (polarity ? rise : fall));

	always_ff @(posedge clk) begin
		if (!rstn)
			cnt_r <= `USFC_CNT_ZERO;
		else if (reload || baudTick)
			cnt_r <= baudDiv;
		else
			cnt_r <= cnt_r - 12'h001;
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			div_r <= 4'h0;
		else if (tk.rxTick)
			div_r <= (div_r == divMax) ? 4'h0 : div_r + 4'h1;
	end

	// master clock halves the tick rate, rests at the polarity level
	always_ff @(posedge clk) begin
		if (!rstn)
			xckOut <= 1'b0;
		else if (!master)
			xckOut <= polarity;
		else if (toggle)
			xckOut <= !xckOut;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			xs1_r    <= 1'b0;
			xs2_r    <= 1'b0;
			xsPrev_r <= 1'b0;
		end else begin
			xs1_r    <= xckIn;
			xs2_r    <= xs1_r;
			xsPrev_r <= xs2_r;
		end
	end
endmodule
`default_nettype wire

// ### logic/usfc_tx.sv
/*
 Transmit shift register with frame builder and parity generator.
 Assumes the load buffer holds its data until loadTake.
*/
`timescale 1ns/100ps
`default_nettype none
`include "usfc_params.svh"
module usfc_tx (
	input  wire logic       clk,
	input  wire logic       rstn,
	usfc_tick_if.sink       tk,
	input  wire logic       syncMode,
	input  wire logic [3:0] nBits,
	input  wire logic       parEn,
	input  wire logic       parOdd,
	input  wire logic       twoStop,
	input  wire logic       loadValid,
	input  wire logic [8:0] loadData,
	output logic            loadTake,
	output logic            serialOut,
	output logic            busy,
	output logic            doneP
);
	logic [12:0] sh_r;
	logic [12:0] frame;
	logic [3:0]  rem_r;

	wire [11:0] dpad     = {3'h7, loadData};
	wire [8:0]  mask     = 9'h1FF >> (`USFC_BITS_NINE - nBits);
	wire        parBit   = (^(loadData & mask)) ^ parOdd;
	wire [3:0]  frameLen = `USFC_FRAME_BASE + nBits + {3'h0, parEn} +
	                       {3'h0, twoStop};
	wire        bitEn    = syncMode ? tk.syncChange : tk.txBitEn;

	assign frame[0] = 1'b0;
	genvar i;
	for (i = 0; i < 12; i++) begin : g_frame
		assign frame[i+1] = (4'(i) < nBits) ? dpad[i] :
		                    (((4'(i) == nBits) && parEn) ? parBit : 1'b1);
	end

	assign busy     = (rem_r != 4'h0);
	assign loadTake = bitEn && (rem_r <= 4'h1) && loadValid;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sh_r      <= 13'h1FFF;
			rem_r     <= 4'h0;
			serialOut <= 1'b1;
			doneP     <= 1'b0;
		end else begin
			doneP <= 1'b0;
			if (bitEn) begin
				if (rem_r > 4'h1) begin
					sh_r      <= {1'b1, sh_r[12:1]};
					serialOut <= sh_r[1];
					rem_r     <= rem_r - 4'h1;
				end else if (loadValid) begin
					sh_r      <= frame;
					serialOut <= frame[0];
					rem_r     <= frameLen;
				end else begin
					serialOut <= 1'b1;
					rem_r     <= 4'h0;
					doneP     <= (rem_r == 4'h1);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### logic/usfc_core.sv
/*
 Serial transceiver core: AXI4-Lite registers, transmit buffer,
 receiver with two-entry buffer, interrupt requests.
 Assumes serialIn and xckIn are asynchronous pins; one clock clk.
*/
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "usfc_params.svh"
// Contract
// - baud counter reloads at zero or low write
// - twelve-bit divisor from high and low registers
// - one baud tick per counter zero
// - transmit bit clock divides by 16, 8, 2
// - receiver uses 16, 8 or 2 states
// - normal async rate is ticks over sixteen
// - double speed halves divisor, async only
// - double speed receiver takes eight samples
// - sync mode: master drives, slave takes clock
// - slave clock synchronised then edge detected
// - sample on edge opposite data change
// - polarity picks change and sample edges
// - thirty frame formats supported
// - start, data lsb first, parity, stops
// - start low, stops high, idle high
// - next frame follows without gap
// - one frame setting for both directions
// - only first stop bit checked
// - framing, overrun and parity errors reported
// - one transmit buffer, two-level receive buffer
// - three separate interrupt requests
// - parity is xor, inverted when odd
// - char size seven means nine bits
module usfc_core (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        serialIn,
	output logic             serialOut,
	input  wire logic        xckIn,
	output logic             xckOut,
	output logic             xckOe,
	output logic             irqTxComplete,
	output logic             irqTxEmpty,
	output logic             irqRxComplete
);
	// ==========================================
	// register bus state
	logic        awReady_r;
	logic        wReady_r;
	logic        bValid_r;
	logic [1:0]  bResp_r;
	logic        arReady_r;
	logic        rValid_r;
	logic [1:0]  rResp_r;
	logic [31:0] rData_r;
	logic        awHeld_r;
	logic        wHeld_r;
	logic [7:0]  awAddr_r;
	logic [7:0]  wData_r;
	logic        wStrb0_r;

	// ==========================================
	// configuration and status state
	logic        dbl_r;
	logic [6:0]  csrB_r;
	logic [7:0]  csrC_r;
	logic [7:0]  baudLo_r;
	logic [3:0]  baudHi_r;
	logic        txc_r;
	logic        dor_r;
	logic        txBufValid_r;
	logic [8:0]  txBufData_r;
	logic        irqTxc_r;
	logic        irqUdre_r;
	logic        irqRxc_r;
	logic        xckOe_r;

	// ==========================================
	// receiver state
	usfc_pkg::usfc_rx_state_t rxState_r;
	logic [3:0]  phase_r;
	logic [3:0]  bitIdx_r;
	logic [8:0]  rxShift_r;
	logic        rxPar_r;
	logic        rxs1_r;
	logic        rxs2_r;
	logic [10:0] rxMem_r [0:1];
	logic        wrPtr_r;
	logic        rdPtr_r;
	logic [1:0]  rxCount_r;

	logic        txTake;
	logic        txBusy;
	logic        txDone;
	usfc_tick_if tick ();

	assign s_axi_awready = awReady_r;
	assign s_axi_wready  = wReady_r;
	assign s_axi_bvalid  = bValid_r;
	assign s_axi_bresp   = bResp_r;
	assign s_axi_arready = arReady_r;
	assign s_axi_rvalid  = rValid_r;
	assign s_axi_rresp   = rResp_r;
	assign s_axi_rdata   = rData_r;
	assign irqTxComplete = irqTxc_r;
	assign irqTxEmpty    = irqUdre_r;
	assign irqRxComplete = irqRxc_r;
	assign xckOe         = xckOe_r;

	// ==========================================
	// field decode, shared by both directions
	wire       syncMode   = csrC_r[`USFC_C_UMSEL];
	wire       slaveMode  = !csrB_r[`USFC_B_XCKDIR];
	wire       polarity   = csrC_r[`USFC_C_UCPOL];
	wire [2:0] charSize   = csrC_r[`USFC_C_CSZ +: 3];
	wire [1:0] parityMode = csrC_r[`USFC_C_PM +: 2];
	wire       parEn      = parityMode[1];
	wire       parOdd     = parityMode[0];
	wire       twoStop    = csrC_r[`USFC_C_SBS];
	wire       rxEn       = csrB_r[`USFC_B_RXEN];
	wire       txEn       = csrB_r[`USFC_B_TXEN];
	wire [3:0] nBits      = (charSize == `USFC_CSZ_NINE) ? `USFC_BITS_NINE :
	                        (charSize[2] ? `USFC_BITS_EIGHT :
	                        `USFC_MIN_BITS + {2'h0, charSize[1:0]});
	wire [8:0] dataMask   = 9'h1FF >> (`USFC_BITS_NINE - nBits);
	wire       dblEff     = dbl_r && !syncMode;
	wire [11:0] baudDiv   = {baudHi_r, baudLo_r};
	wire [3:0] osMax      = dblEff ? `USFC_OS_DBL : `USFC_OS_NORM;
	wire [3:0] midIdx     = dblEff ? `USFC_MID_DBL : `USFC_MID_NORM;

	// ==========================================
	// write decode
	wire doWrite  = awHeld_r && wHeld_r && !bValid_r;
	wire wrEn     = doWrite && wStrb0_r;
	wire wrData   = wrEn && (awAddr_r == `USFC_OFS_DATA);
	wire wrA      = wrEn && (awAddr_r == `USFC_OFS_CSRA);
	wire wrB      = wrEn && (awAddr_r == `USFC_OFS_CSRB);
	wire wrC      = wrEn && (awAddr_r == `USFC_OFS_CSRC);
	wire wrLo     = wrEn && (awAddr_r == `USFC_OFS_BDLO);
	wire wrHi     = wrEn && (awAddr_r == `USFC_OFS_BDHI);
	wire wrMapped = (awAddr_r == `USFC_OFS_DATA) ||
	                (awAddr_r == `USFC_OFS_CSRA) ||
	                (awAddr_r == `USFC_OFS_CSRB) ||
	                (awAddr_r == `USFC_OFS_CSRC) ||
	                (awAddr_r == `USFC_OFS_BDLO) ||
	                (awAddr_r == `USFC_OFS_BDHI);

	// ==========================================
	// read decode
	wire [7:0]  arAddr   = s_axi_araddr[7:0];
	wire        rdTake   = s_axi_arvalid && arReady_r;
	wire [10:0] rxHead   = rxMem_r[rdPtr_r];
	wire        rxAvail  = (rxCount_r != 2'h0);
	wire        rdPop    = rdTake && (arAddr == `USFC_OFS_DATA) && rxAvail;
	wire [7:0]  csrAView = {1'b0, rxAvail && rxHead[10], dor_r,
	                        rxAvail && rxHead[9], txc_r, !txBufValid_r,
	                        rxAvail, dbl_r};
	wire        rdMapped = (arAddr == `USFC_OFS_DATA) ||
	                       (arAddr == `USFC_OFS_CSRA) ||
	                       (arAddr == `USFC_OFS_CSRB) ||
	                       (arAddr == `USFC_OFS_CSRC) ||
	                       (arAddr == `USFC_OFS_BDLO) ||
	                       (arAddr == `USFC_OFS_BDHI);
	wire [31:0] rdMux    =
		(arAddr == `USFC_OFS_DATA) ?
			{23'h000000, rxAvail ? rxHead[8:0] : 9'h000} :
		(arAddr == `USFC_OFS_CSRA) ? {24'h000000, csrAView} :
		(arAddr == `USFC_OFS_CSRB) ? {25'h0000000, csrB_r} :
		(arAddr == `USFC_OFS_CSRC) ? {24'h000000, csrC_r} :
		(arAddr == `USFC_OFS_BDLO) ? {24'h000000, baudLo_r} :
		(arAddr == `USFC_OFS_BDHI) ? {28'h0000000, baudHi_r} :
		32'h00000000;

	// ==========================================
	// write channels: address and data in either order
	always_ff @(posedge clk) begin
		if (!rstn) begin
			awReady_r <= 1'b1;
			wReady_r  <= 1'b1;
			awHeld_r  <= 1'b0;
			wHeld_r   <= 1'b0;
			awAddr_r  <= 8'h00;
			wData_r   <= 8'h00;
			wStrb0_r  <= 1'b0;
			bValid_r  <= 1'b0;
			bResp_r   <= `USFC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awReady_r) begin
				awHeld_r  <= 1'b1;
				awReady_r <= 1'b0;
				awAddr_r  <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && wReady_r) begin
				wHeld_r  <= 1'b1;
				wReady_r <= 1'b0;
				wData_r  <= s_axi_wdata[7:0];
				wStrb0_r <= s_axi_wstrb[0];
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r  <= 1'b0;
				bValid_r <= 1'b1;
				bResp_r  <= wrMapped ? `USFC_RESP_OKAY : `USFC_RESP_SLVERR;
			end
			if (bValid_r && s_axi_bready) begin
				bValid_r  <= 1'b0;
				awReady_r <= 1'b1;
				wReady_r  <= 1'b1;
			end
		end
	end

	// ==========================================
	// read channel
	always_ff @(posedge clk) begin
		if (!rstn) begin
			arReady_r <= 1'b1;
			rValid_r  <= 1'b0;
			rResp_r   <= `USFC_RESP_OKAY;
			rData_r   <= 32'h00000000;
		end else if (rdTake) begin
			arReady_r <= 1'b0;
			rValid_r  <= 1'b1;
			rData_r   <= rdMux;
			rResp_r   <= rdMapped ? `USFC_RESP_OKAY : `USFC_RESP_SLVERR;
		end else if (rValid_r && s_axi_rready) begin
			rValid_r  <= 1'b0;
			arReady_r <= 1'b1;
		end
	end

	// ==========================================
	// configuration registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dbl_r    <= 1'b0;
			csrB_r   <= 7'h00;
			csrC_r   <= `USFC_RST_C;
			baudLo_r <= 8'h00;
			baudHi_r <= 4'h0;
		end else begin
			if (wrA)
				dbl_r <= wData_r[`USFC_A_U2X];
			if (wrB)
				csrB_r <= wData_r[6:0];
			if (wrC)
				csrC_r <= wData_r;
			if (wrLo)
				baudLo_r <= wData_r;
			if (wrHi)
				baudHi_r <= wData_r[3:0];
		end
	end

	// ==========================================
	// transmit buffer and completion flag
	always_ff @(posedge clk) begin
		if (!rstn) begin
			txBufValid_r <= 1'b0;
			txBufData_r  <= 9'h000;
		end else if (wrData && !txBufValid_r) begin
			txBufValid_r <= 1'b1;
			txBufData_r  <= {csrB_r[`USFC_B_TX9], wData_r};
		end else if (txTake) begin
			txBufValid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			txc_r <= 1'b0;
		else if (txDone)
			txc_r <= 1'b1;
		else if (wrA && wData_r[`USFC_A_TXC])
			txc_r <= 1'b0;
	end

	// ==========================================
	// clock generator and transmitter
	usfc_baud_gen u_gen (
		.clk       (clk),
		.rstn      (rstn),
		.baudDiv   (baudDiv),
		.reload    (wrLo),
		.syncMode  (syncMode),
		.slaveMode (slaveMode),
		.dblSpeed  (dblEff),
		.polarity  (polarity),
		.runClk    (txBusy || (txBufValid_r && txEn)),
		.xckIn     (xckIn),
		.xckOut    (xckOut),
		.tk        (tick)
	);

	usfc_tx u_tx (
		.clk       (clk),
		.rstn      (rstn),
		.tk        (tick),
		.syncMode  (syncMode),
		.nBits     (nBits),
		.parEn     (parEn),
		.parOdd    (parOdd),
		.twoStop   (twoStop),
		.loadValid (txBufValid_r && txEn),
		.loadData  (txBufData_r),
		.loadTake  (txTake),
		.serialOut (serialOut),
		.busy      (txBusy),
		.doneP     (txDone)
	);

	// ==========================================
	// receiver
	wire rxLine    = rxs2_r;
	wire startSeen = syncMode ? (tick.syncSample && !rxLine) :
	                 (tick.rxTick && !rxLine);
	wire sampleNow = syncMode ? tick.syncSample :
	                 (tick.rxTick && (phase_r == midIdx));
	wire frameDone = rxEn && (rxState_r == usfc_pkg::RX_STOP) && sampleNow;
	wire rxFe      = !rxLine;
	wire rxPe      = parEn &&
	                 (((^(rxShift_r & dataMask)) ^ parOdd) != rxPar_r);
	wire fifoFull  = (rxCount_r == `USFC_FIFO_DEPTH);
	wire rxPush    = frameDone && !fifoFull;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rxs1_r <= 1'b1;
			rxs2_r <= 1'b1;
		end else begin
			rxs1_r <= serialIn;
			rxs2_r <= rxs1_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rxState_r <= usfc_pkg::RX_IDLE;
			phase_r   <= 4'h0;
			bitIdx_r  <= 4'h0;
			rxShift_r <= 9'h000;
			rxPar_r   <= 1'b0;
		end else if (!rxEn) begin
			rxState_r <= usfc_pkg::RX_IDLE;
		end else begin
			if (tick.rxTick)
				phase_r <= (phase_r == osMax) ? 4'h0 : phase_r + 4'h1;
			unique case (rxState_r)
			usfc_pkg::RX_IDLE: if (startSeen) begin
				rxShift_r <= 9'h000;
				bitIdx_r  <= 4'h0;
				phase_r   <= 4'h1;
				rxState_r <= syncMode ? usfc_pkg::RX_DATA : usfc_pkg::RX_START;
			end
			usfc_pkg::RX_START: if (sampleNow) begin
				// false start returns to idle
				rxState_r <= rxLine ? usfc_pkg::RX_IDLE : usfc_pkg::RX_DATA;
			end
			usfc_pkg::RX_DATA: if (sampleNow) begin
				rxShift_r[bitIdx_r] <= rxLine;
				bitIdx_r <= bitIdx_r + 4'h1;
				if (bitIdx_r == nBits - 4'h1)
					rxState_r <= parEn ? usfc_pkg::RX_PAR : usfc_pkg::RX_STOP;
			end
			usfc_pkg::RX_PAR: if (sampleNow) begin
				rxPar_r   <= rxLine;
				rxState_r <= usfc_pkg::RX_STOP;
			end
			usfc_pkg::RX_STOP: if (sampleNow) begin
				rxState_r <= usfc_pkg::RX_IDLE;
			end
			endcase
		end
	end

	// ==========================================
	// two-entry receive buffer
	always_ff @(posedge clk) begin
		if (rxPush)
			rxMem_r[wrPtr_r] <= {rxPe, rxFe, rxShift_r};
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wrPtr_r   <= 1'b0;
			rdPtr_r   <= 1'b0;
			rxCount_r <= 2'h0;
		end else begin
			if (rxPush)
				wrPtr_r <= !wrPtr_r;
			if (rdPop)
				rdPtr_r <= !rdPtr_r;
			rxCount_r <= rxCount_r + {1'b0, rxPush} - {1'b0, rdPop};
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			dor_r <= 1'b0;
		else if (frameDone && fifoFull)
			dor_r <= 1'b1;
		else if (rdPop)
			dor_r <= 1'b0;
	end

	// ==========================================
	// interrupt requests and pin direction
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irqTxc_r  <= 1'b0;
			irqUdre_r <= 1'b0;
			irqRxc_r  <= 1'b0;
			xckOe_r   <= 1'b0;
		end else begin
			irqTxc_r  <= txc_r && csrB_r[`USFC_B_TXCIE];
			irqUdre_r <= !txBufValid_r && csrB_r[`USFC_B_UDRIE];
			irqRxc_r  <= rxAvail && csrB_r[`USFC_B_RXCIE];
			xckOe_r   <= syncMode && !slaveMode;
		end
	end
endmodule
`default_nettype wire

// ### dv/usfc_core_props.sv
/*
 Checker of the usfc_core ports.
 Assumes it is bound to usfc_core.
*/
`timescale 1ns/100ps
`default_nettype none
module usfc_core_props (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        serialOut
);
// ========
// bus and line
default clocking cb @(posedge clk); endclocking
default disable iff (!rstn);
write_resp_time_a: assert property (s_axi_awvalid && s_axi_awready
	&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
	else $error("write response late");
read_resp_time_a: assert property (s_axi_arvalid && s_axi_arready
	|=> s_axi_rvalid) else $error("read data late");
write_busy_a: assert property (s_axi_bvalid
	|-> !s_axi_awready && !s_axi_wready) else $error("ready early");
write_done_a: assert property (s_axi_bvalid && s_axi_bready
	|=> !s_axi_bvalid && s_axi_awready) else $error("write not freed");
read_done_a: assert property (s_axi_rvalid && s_axi_rready
	|=> !s_axi_rvalid && s_axi_arready) else $error("read not freed");
read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("arready early");
unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
	|-> s_axi_rdata == 32'h0) else $error("error read not zero");
start_bit_a: assert property ($fell(serialOut) |-> !serialOut [*2])
	else $error("start bit short");
cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
cover property ($fell(serialOut));
cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind usfc_core usfc_core_props u_props (.*);
`default_nettype wire

// ### dv/usfc_peer.sv
/*
 Remote serial transceiver model.
 Assumes the bench calls send and recv; line idles high.
*/
`timescale 1ns/100ps
`default_nettype none
module usfc_peer (
	input  wire logic clk,
	input  wire logic serialOut,
	input  wire logic xckOut,
	output var logic  serialIn,
	output var logic  xckIn
);
// transfer clock held still: async or sync master only, below clk/4
initial begin
	serialIn = 1'b1;
	xckIn = 1'b0;
end
// start low, bits lsb first, line back high
task automatic send(input logic [11:0] b, input int n, input int per);
	serialIn <= 1'b0;
	repeat (per) @(posedge clk);
	for (int i = 0; i < n; i++) begin
		serialIn <= b[i];
		repeat (per) @(posedge clk);
	end
	serialIn <= 1'b1;
endtask
// samples mid bit after the start edge
task automatic recv(input int n, input int per, output logic [11:0] v);
	v = 12'h000;
	@(negedge serialOut);
	repeat (per / 2) @(posedge clk);
	for (int i = 0; i < n; i++) begin
		repeat (per) @(posedge clk);
		v[i] = serialOut;
	end
endtask
// master clock, polarity zero: sample on falling edge
task automatic recvSync(input int n, output logic [11:0] v);
	v = 12'h000;
	for (int i = 0; i < n; i++) begin
		@(negedge xckOut);
		v[i] = serialOut;
	end
endtask
endmodule
`default_nettype wire

// ### dv/usart_clock_and_frame_core_tb_top.sv
/*
 Bench of usfc_core over its register bus and serial line.
 Assumes usfc_peer and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module usart_clock_and_frame_core_tb_top;
logic        clk, rstn, serialIn, serialOut, xckIn, xckOut, xckOe;
logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
logic [3:0]  s_axi_wstrb;
logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
logic        s_axi_rvalid, s_axi_rready;
logic        irqTxComplete, irqTxEmpty, irqRxComplete;
logic [11:0] v;
int          fails, checked;
usfc_core DUT (.*);
usfc_peer peer (.*);
// ========
// bus tasks
task automatic wr(input logic [7:0] a, input logic [31:0] d);
	@(posedge clk);
	s_axi_awaddr <= {24'h0, a};
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	do begin
		@(posedge clk);
		if (s_axi_awready) s_axi_awvalid <= 1'b0;
		if (s_axi_wready) s_axi_wvalid <= 1'b0;
	end while (s_axi_bvalid !== 1'b1);
	rsp = s_axi_bresp;
	s_axi_bready <= 1'b0;
endtask
task automatic rd(input logic [7:0] a);
	@(posedge clk);
	s_axi_araddr <= {24'h0, a};
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do begin
		@(posedge clk);
		if (s_axi_arready) s_axi_arvalid <= 1'b0;
	end while (s_axi_rvalid !== 1'b1);
	rdv = s_axi_rdata;
	rsp = s_axi_rresp;
	s_axi_rready <= 1'b0;
endtask
task automatic rxWait;
	do rd(8'h04);
	while (rdv[1] !== 1'b1);
endtask
task automatic chk(input logic [31:0] g, input logic [31:0] e);
	checked++;
	if (g !== e) begin
		fails++;
		$display("unexpected at %0t: got %h exp %h", $time, g, e);
	end
endtask
task automatic close_out;
	$display("checked %0d fails %0d", checked, fails);
	if (fails == 0 && checked > 0) begin
		$display("bench passed");
	end else begin
		$display("bench failed");
	end
	$finish;
endtask
// ========
// clock, watchdog, tests
initial begin
	clk = 1'b0;
	forever #2 clk = ~clk;
end
initial begin
	repeat (30000) @(posedge clk);
	fails++;
	close_out;
end
initial begin
	{rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
	{s_axi_arvalid, s_axi_rready} = 2'h0;
	{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
	s_axi_wstrb = 4'hF;
	repeat (6) @(posedge clk);
	rstn <= 1'b1;
	rd(8'h0C);
	chk(rdv, 32'h06);
	rd(8'h18);
	chk(rdv, 32'h0);
	chk({30'h0, rsp}, 32'h2);
	wr(8'h18, 32'h0);
	chk({30'h0, rsp}, 32'h2);
	wr(8'h10, 32'h1);
	wr(8'h14, 32'h0);
	wr(8'h0C, 32'h03);
	wr(8'h08, 32'h3);
	fork
		peer.recv(9, 32, v);
		wr(8'h00, 32'hA5);
	join
	chk({20'h0, v}, 32'h1A5);
	peer.send(12'h13C, 9, 32);
	rxWait;
	rd(8'h00);
	chk(rdv & 32'hFF, 32'h3C);
	peer.send(12'h0F0, 9, 32);
	rxWait;
	chk(rdv & 32'h10, 32'h10);
	rd(8'h00);
	// low stop bit reads as a new start: drop it
	wr(8'h08, 32'h2);
	wr(8'h08, 32'h3);
	wr(8'h0C, 32'h1B);
	fork
		peer.recv(10, 32, v);
		wr(8'h00, 32'h01);
	join
	chk({20'h0, v}, 32'h201);
	peer.send(12'h301, 10, 32);
	rxWait;
	chk(rdv & 32'h40, 32'h40);
	rd(8'h00);
	wr(8'h0C, 32'h20);
	fork
		peer.recv(7, 32, v);
		wr(8'h00, 32'h16);
	join
	chk({20'h0, v}, 32'h76);
	wr(8'h0C, 32'h03);
	wr(8'h04, 32'h01);
	fork
		peer.recv(9, 16, v);
		wr(8'h00, 32'h5A);
	join
	chk({20'h0, v}, 32'h15A);
	peer.send(12'h1C3, 9, 16);
	rxWait;
	rd(8'h00);
	chk(rdv & 32'hFF, 32'hC3);
	wr(8'h08, 32'h0B);
	wr(8'h0C, 32'h43);
	@(posedge clk);
	chk({31'h0, xckOe}, 32'h1);
	fork
		peer.recvSync(10, v);
		wr(8'h00, 32'hA5);
	join
	chk({20'h0, v}, 32'h34A);
	repeat (8) @(posedge clk);
	chk({31'h0, xckOut}, 32'h0);
	wr(8'h08, 32'h7B);
	@(posedge clk);
	chk({29'h0, irqTxComplete, irqTxEmpty, irqRxComplete},
		32'h6);
	wr(8'h04, 32'h08);
	@(posedge clk);
	chk({31'h0, irqTxComplete}, 32'h0);
	close_out;
end
endmodule
`default_nettype wire
